// >>> core/tss_pkg.sv
package tss_pkg;

    // ==========================================================
    // Sizes
    localparam int          NUM_STREAMS = 64;
    localparam int          DM_DEPTH    = 32768;
    localparam int          NUM_BUFS    = 3;

    // ==========================================================
    // Timing
    localparam int          FRAME_NS         = 125000;
    localparam int          MCLK_KHZ         = 32768;
    localparam int          SYS_CLK_NS       = 10;
    localparam int          FRAME_HALF_EDGES = 2 * FRAME_NS / 1000 * MCLK_KHZ / 1000;
    localparam logic [13:0] HALF_SAT         = 14'h3fff;
    localparam logic [3:0]  POL_STABLE_EDGES = 4'h8;

    // ==========================================================
    // Rate codes and channel modes
    localparam logic [2:0]  RATE_MAX   = 3'h4;
    localparam logic [2:0]  MODE_VAR   = 3'h0;
    localparam logic [2:0]  MODE_CONST = 3'h1;
    localparam logic [2:0]  MODE_PROC  = 3'h4;
    localparam logic [2:0]  MODE_BERT  = 3'h5;
    localparam logic [2:0]  MODE_HIZ   = 3'h7;

    // ==========================================================
    // Reset values
    localparam logic [14:0] BERT_SEED     = 15'h7fff;
    localparam logic [1:0]  FRAME_BUF_RST = 2'h0;

    function automatic logic [2:0] rate_clamp(input logic [2:0] r);
        return (r > RATE_MAX) ? RATE_MAX : r;
    endfunction : rate_clamp

    // Log2 of master half-edges per bit
    function automatic logic [2:0] bit_shift(input logic [2:0] r);
        return 3'h5 - rate_clamp(r);
    endfunction : bit_shift

    function automatic logic [13:0] half_mask(input logic [2:0] r);
        return (14'h0001 << bit_shift(r)) - 14'h0001;
    endfunction : half_mask

    function automatic logic [10:0] last_chan(input logic [2:0] r);
        return (11'h020 << rate_clamp(r)) - 11'h001;
    endfunction : last_chan

    function automatic logic [1:0] buf_next(input logic [1:0] b);
        return (b == 2'h2) ? 2'h0 : b + 2'h1;
    endfunction : buf_next

endpackage : tss_pkg

// >>> core/tss_rx_deser.sv
`timescale 1ns/1ps
`default_nettype none
module tss_rx_deser
    import tss_pkg::*;
(
    // Clock and reset
    input  wire logic       clk_in,
    input  wire logic       rst_n_in,
    // Timing
    input  wire logic       edge_in,
    input  wire logic       frame_in,
    input  wire logic [2:0] rate_in,
    input  wire logic [3:0] offset_in,
    // Stream
    input  wire logic       data_in,
    // Word
    output logic            word_valid_out,
    output logic [8:0]      word_chan_out,
    output logic [7:0]      word_out
);
    typedef struct packed {
        logic [13:0] hc;
        logic [7:0]  shift;
        logic        valid;
        logic [8:0]  chan;
        logic [7:0]  word;
    } tss_rx_state_t;

    tss_rx_state_t s_q;
    tss_rx_state_t s_d;

    logic [13:0] idx;
    logic [13:0] pos;
    logic [13:0] bn;
    logic [7:0]  nxt;

    always_comb begin
        s_d       = s_q;
        s_d.valid = 1'b0;
        idx       = frame_in ? 14'h0000 : s_q.hc;
        pos       = (idx >= {10'h000, offset_in}) ? idx - {10'h000, offset_in}
                    : idx + 14'(FRAME_HALF_EDGES) - {10'h000, offset_in};
        bn        = pos >> bit_shift(rate_in);
        nxt       = {s_q.shift[6:0], data_in};
        if (edge_in) begin
            s_d.hc = (idx == HALF_SAT) ? HALF_SAT : idx + 14'h0001;
            if ((pos & half_mask(rate_in)) == half_mask(rate_in)
                && bn[13:3] <= last_chan(rate_in)) begin
                s_d.shift = nxt;
                if (bn[2:0] == 3'h7) begin
                    s_d.valid = 1'b1;
                    s_d.chan  = bn[11:3];
                    s_d.word  = nxt;
                end
            end
        end
    end

    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign word_valid_out = s_q.valid;
    assign word_chan_out  = s_q.chan;
    assign word_out       = s_q.word;

    // ==========================================================
    // Checks
    a_rx_word_last: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        word_valid_out |-> $past(edge_in) && word_out[0] == $past(data_in))
        else $error("rx word not built from sampled bit");

endmodule : tss_rx_deser
`default_nettype wire

// >>> core/tss_tx_ser.sv
`timescale 1ns/1ps
`default_nettype none
module tss_tx_ser
    import tss_pkg::*;
(
    // Clock and reset
    input  wire logic       clk_in,
    input  wire logic       rst_n_in,
    // Timing
    input  wire logic       edge_in,
    input  wire logic       frame_in,
    input  wire logic [2:0] rate_in,
    // Channel data
    input  wire logic [7:0] byte_in,
    input  wire logic       hiz_in,
    // Fetch request
    output logic            fetch_out,
    output logic [8:0]      fetch_chan_out,
    // Stream
    output logic            tx_out,
    output logic            oe_n_out,
    output logic            drive_out
);
    typedef struct packed {
        logic [13:0] hc;
        logic [7:0]  shift;
        logic        tx;
        logic        drive;
        logic        fetch;
        logic [8:0]  fchan;
    } tss_tx_state_t;

    tss_tx_state_t s_q;
    tss_tx_state_t s_d;

    logic [13:0] idx;
    logic [13:0] bn;
    logic        launch;

    always_comb begin
        s_d       = s_q;
        s_d.fetch = 1'b0;
        idx       = frame_in ? 14'h0000 : s_q.hc;
        bn        = idx >> bit_shift(rate_in);
        launch    = edge_in && (idx & half_mask(rate_in)) == 14'h0000
                    && bn[13:3] <= last_chan(rate_in);
        if (edge_in) begin
            s_d.hc = (idx == HALF_SAT) ? HALF_SAT : idx + 14'h0001;
        end
        if (launch) begin
            if (bn[2:0] == 3'h0) begin
                s_d.shift = byte_in;
                s_d.tx    = byte_in[7];
                s_d.drive = !hiz_in;
            end else begin
                s_d.shift = {s_q.shift[6:0], 1'b0};
                s_d.tx    = s_q.shift[6];
            end
            if (bn[2:0] == 3'h7) begin
                s_d.fetch = 1'b1;
                s_d.fchan = (bn[13:3] == last_chan(rate_in)) ? 9'h000 : 9'(bn[11:3] + 9'h001);
            end
        end
    end

    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign fetch_out      = s_q.fetch;
    assign fetch_chan_out = s_q.fchan;
    assign tx_out         = s_q.tx;
    assign oe_n_out       = !s_q.drive;
    assign drive_out      = s_q.drive;

    // ==========================================================
    // Checks
    a_tx_launch_edge: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        $changed(tx_out) |-> $past(edge_in))
        else $error("tx bit changed off a master edge");

    a_tx_drive_load: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        $changed(drive_out) |-> $past(launch) && drive_out == !$past(hiz_in))
        else $error("tx drive changed outside channel load");

endmodule : tss_tx_ser
`default_nettype wire

// >>> core/tss_switch_core.sv
`timescale 1ns/1ps
`default_nettype none
module tss_switch_core
    import tss_pkg::*;
(
    // Clock and reset
    input  wire logic          clk_sys_in,
    input  wire logic          rst_n_in,
    // Stream timing pins
    input  wire logic          master_clock_input_in,
    input  wire logic          frame_pulse_input_in,
    // Input streams and stream setup
    input  wire logic [63:0]   rx_data_in,
    input  wire logic [191:0]  rx_rate_in,
    input  wire logic [255:0]  rx_offset_in,
    input  wire logic [191:0]  tx_rate_in,
    // Connection memory write port
    input  wire logic          cm_wr_in,
    input  wire logic          cm_high_in,
    input  wire logic [14:0]   cm_addr_in,
    input  wire logic [15:0]   cm_wdata_in,
    // Output streams
    output logic [63:0]        tx_data_out,
    output logic [63:0]        tx_oe_n_out,
    output logic [63:0]        output_drive_indicator_out,
    output logic               gci_mode_out
);
    typedef struct packed {
        logic [2:0]        mclk_s;
        logic              mclk_f;
        logic [2:0]        fp_s;
        logic              fp_f;
        logic              fp_prev;
        logic              fp_last;
        logic [3:0]        stable;
        logic              fp_idle;
        logic              gci;
        logic              armed;
        logic              edge_p;
        logic              frame_p;
        logic [1:0]        frm;
        logic [14:0]       lfsr;
        logic [63:0][7:0]  fb;
        logic [63:0]       hz;
        logic [63:0]       rx_s1;
        logic [63:0]       rx_s2;
        logic [63:0]       rx_s3;
        logic [63:0]       rx_f;
    } tss_top_state_t;

    tss_top_state_t s_q;
    tss_top_state_t s_d;

    logic [1:0]        rst_sync_q;
    logic              rst_n;

    logic [63:0]       rx_valid;
    logic [63:0][8:0]  rx_chan;
    logic [63:0][7:0]  rx_word;
    logic [63:0]       tx_fetch;
    logic [63:0][8:0]  tx_fchan;

    logic [7:0]        dm_c [0:NUM_BUFS-1][0:DM_DEPTH-1];
    logic [7:0]        dm_v [0:DM_DEPTH-1];
    logic [15:0]       cm_lo [0:DM_DEPTH-1];
    logic [2:0]        cm_hi [0:DM_DEPTH-1];

    logic              mclk_new;
    logic              fp_new;
    logic              rise;
    logic              fall;
    logic              bert_any;
    logic [14:0]       ca;
    logic [15:0]       lo;
    logic [1:0]        rbuf;

    // ==========================================================
    // Reset release
    always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            rst_sync_q <= 2'h0;
        end else begin
            rst_sync_q <= {rst_sync_q[0], 1'b1};
        end
    end
    assign rst_n = rst_sync_q[1];

    // ==========================================================
    // Timing, polarity and channel fetch
    always_comb begin
        s_d         = s_q;
        bert_any    = 1'b0;
        ca          = 15'h0000;
        lo          = 16'h0000;
        rbuf        = 2'h0;
        s_d.mclk_s  = {s_q.mclk_s[1:0], master_clock_input_in};
        s_d.fp_s    = {s_q.fp_s[1:0], frame_pulse_input_in};
        s_d.rx_s1   = rx_data_in;
        s_d.rx_s2   = s_q.rx_s1;
        s_d.rx_s3   = s_q.rx_s2;
        for (int s = 0; s < NUM_STREAMS; s++) begin
            if (s_q.rx_s2[s] == s_q.rx_s3[s]) begin
                s_d.rx_f[s] = s_q.rx_s3[s];
            end
        end
        mclk_new    = (s_q.mclk_s[1] == s_q.mclk_s[2]) ? s_q.mclk_s[2] : s_q.mclk_f;
        fp_new      = (s_q.fp_s[1] == s_q.fp_s[2]) ? s_q.fp_s[2] : s_q.fp_f;
        rise        = mclk_new && !s_q.mclk_f;
        fall        = !mclk_new && s_q.mclk_f;
        s_d.mclk_f  = mclk_new;
        s_d.fp_f    = fp_new;
        s_d.fp_prev = s_q.fp_f;
        s_d.edge_p  = rise || fall;
        s_d.frame_p = s_q.armed && (s_q.gci ? rise : fall);
        if (rise) begin
            s_d.fp_last = s_q.fp_f;
            if (s_q.fp_f != s_q.fp_last) begin
                s_d.stable = 4'h0;
            end else if (s_q.stable != POL_STABLE_EDGES) begin
                s_d.stable = s_q.stable + 4'h1;
            end else begin
                s_d.fp_idle = s_q.fp_f;
                s_d.gci     = !s_q.fp_f;
            end
        end
        if (s_d.frame_p) begin
            s_d.armed = 1'b0;
            s_d.frm   = buf_next(s_q.frm);
        end else if (s_q.fp_f != s_q.fp_idle && s_q.fp_prev == s_q.fp_idle) begin
            s_d.armed = 1'b1;
        end
        for (int s = 0; s < NUM_STREAMS; s++) begin
            if (tx_fetch[s]) begin
                ca        = {6'(s), tx_fchan[s]};
                lo        = cm_lo[ca];
                rbuf      = (tx_fchan[s] == 9'h000) ? buf_next(buf_next(s_q.frm))
                                                    : buf_next(s_q.frm);
                s_d.hz[s] = 1'b0;
                case (cm_hi[ca])
                    MODE_PROC: begin
                        s_d.fb[s] = lo[7:0];
                    end
                    MODE_BERT: begin
                        s_d.fb[s] = s_q.lfsr[7:0];
                        bert_any  = 1'b1;
                    end
                    MODE_CONST: begin
                        s_d.fb[s] = dm_c[rbuf][lo[14:0]];
                    end
                    MODE_VAR: begin
                        s_d.fb[s] = dm_v[lo[14:0]];
                    end
                    default: begin
                        s_d.hz[s] = 1'b1;
                    end
                endcase
            end
        end
        if (bert_any) begin
            s_d.lfsr = {s_q.lfsr[13:0], s_q.lfsr[14] ^ s_q.lfsr[13]};
        end
    end

    always_ff @(posedge clk_sys_in or negedge rst_n) begin
        if (!rst_n) begin
            s_q         <= '0;
            s_q.fp_idle <= 1'b1;
            s_q.fp_last <= 1'b1;
            s_q.frm     <= FRAME_BUF_RST;
            s_q.lfsr    <= BERT_SEED;
            s_q.hz      <= '1;
        end else begin
            s_q <= s_d;
        end
    end

    // ==========================================================
    // Memories
    always_ff @(posedge clk_sys_in) begin
        for (int s = 0; s < NUM_STREAMS; s++) begin
            if (rx_valid[s]) begin
                dm_c[s_q.frm][{6'(s), rx_chan[s]}] <= rx_word[s];
                dm_v[{6'(s), rx_chan[s]}]           <= rx_word[s];
            end
        end
        if (cm_wr_in && cm_high_in) begin
            cm_hi[cm_addr_in] <= cm_wdata_in[2:0];
        end else if (cm_wr_in) begin
            cm_lo[cm_addr_in] <= cm_wdata_in;
        end
    end

    // ==========================================================
    // Stream engines
    for (genvar g = 0; g < NUM_STREAMS; g++) begin : g_stream
        tss_rx_deser u_rx (
            .clk_in         (clk_sys_in),
            .rst_n_in       (rst_n),
            .edge_in        (s_q.edge_p),
            .frame_in       (s_q.frame_p),
            .rate_in        (rx_rate_in[3*g +: 3]),
            .offset_in      (rx_offset_in[4*g +: 4]),
            .data_in        (s_q.rx_f[g]),
            .word_valid_out (rx_valid[g]),
            .word_chan_out  (rx_chan[g]),
            .word_out       (rx_word[g])
        );
        tss_tx_ser u_tx (
            .clk_in         (clk_sys_in),
            .rst_n_in       (rst_n),
            .edge_in        (s_q.edge_p),
            .frame_in       (s_q.frame_p),
            .rate_in        (tx_rate_in[3*g +: 3]),
            .byte_in        (s_q.fb[g]),
            .hiz_in         (s_q.hz[g]),
            .fetch_out      (tx_fetch[g]),
            .fetch_chan_out (tx_fchan[g]),
            .tx_out         (tx_data_out[g]),
            .oe_n_out       (tx_oe_n_out[g]),
            .drive_out      (output_drive_indicator_out[g])
        );
    end

    assign gci_mode_out = s_q.gci;

    // ==========================================================
    // Checks
    logic [14:0] a_ca0;
    logic [15:0] a_lo0;
    logic [2:0]  a_md0;
    logic [7:0]  a_var0;
    assign a_ca0  = {6'h00, tx_fchan[0]};
    assign a_lo0  = cm_lo[a_ca0];
    assign a_md0  = cm_hi[a_ca0];
    assign a_var0 = dm_v[a_lo0[14:0]];

    a_hiz_channel: assert property (@(posedge clk_sys_in) disable iff (!rst_n)
        tx_fetch[0] && a_md0 == MODE_HIZ |=> s_q.hz[0])
        else $error("floating mode did not mark channel");

    a_proc_data: assert property (@(posedge clk_sys_in) disable iff (!rst_n)
        tx_fetch[0] && a_md0 == MODE_PROC |=> !s_q.hz[0] && s_q.fb[0] == $past(a_lo0[7:0]))
        else $error("processor byte not taken from low word");

    a_bert_data: assert property (@(posedge clk_sys_in) disable iff (!rst_n)
        tx_fetch[0] && a_md0 == MODE_BERT |=> s_q.fb[0] == $past(s_q.lfsr[7:0])
        && s_q.lfsr != $past(s_q.lfsr))
        else $error("test pattern not sent or not stepped");

    a_var_source: assert property (@(posedge clk_sys_in) disable iff (!rst_n)
        tx_fetch[0] && a_md0 == MODE_VAR |=> s_q.fb[0] == $past(a_var0))
        else $error("variable delay source address wrong");

    a_frame_edge: assert property (@(posedge clk_sys_in) disable iff (!rst_n)
        s_q.frame_p |-> s_q.edge_p && s_q.mclk_f == s_q.gci)
        else $error("frame start not on launch edge");

    a_frame_buffer: assert property (@(posedge clk_sys_in) disable iff (!rst_n)
        s_q.frame_p |-> s_q.frm == buf_next($past(s_q.frm)))
        else $error("frame buffer index did not step");

    a_polarity_pick: assert property (@(posedge clk_sys_in) disable iff (!rst_n)
        $changed(s_q.fp_idle) |-> $past(s_q.stable) == POL_STABLE_EDGES
        && s_q.gci == !s_q.fp_idle)
        else $error("polarity changed without stable idle level");

    a_edge_pulse: assert property (@(posedge clk_sys_in) disable iff (!rst_n)
        s_q.edge_p |-> $changed(s_q.mclk_f) ##1 !s_q.edge_p)
        else $error("edge pulse not tied to master clock change");

endmodule : tss_switch_core
`default_nettype wire

// >>> dv/tss_stream_partner.sv
`timescale 1ns/1ps
`default_nettype none
// ==========================================================
// Stream partner: master clock, frame pulse, sources, sink
module tss_stream_partner (
    // Control
    input  wire logic         run_in,
    input  wire logic [191:0] rx_rate_in,
    input  wire logic [255:0] rx_offset_in,
    // Sink side of output stream 0
    input  wire logic         tx_in,
    input  wire logic         oe_n_in,
    input  wire logic         drive_in,
    // Timing and sources
    output logic              mclk_out,
    output logic              fp_out,
    output logic [63:0]       rx_out,
    // Channel report
    output logic              rep_out,
    output logic [1:0]        rep_frame_out,
    output logic [8:0]        rep_chan_out,
    output logic [7:0]        rep_byte_out,
    output logic              rep_oe_n_out,
    output logic              rep_drive_out
);
    int         g;
    int         g0;
    int         i;
    int         n;
    logic [7:0] sr;
    logic [7:0] b;

    // Source byte pattern
    function automatic logic [7:0] src_byte(input int f, input int s, input int c);
        return c[7:0] ^ {c[8], f[1:0], s[1:0], 3'h5};
    endfunction : src_byte

    // Slowed master clock, runs free
    initial begin
        mclk_out = 1'b1;
        fp_out   = 1'b1;
        rx_out   = '0;
        rep_out  = 1'b0;
        sr       = '0;
        g        = 0;
        g0       = -1;
        forever #40 mclk_out = ~mclk_out;
    end

    // Idle-high pulse, one clock wide, starting half a clock before each frame start
    always @(posedge mclk_out) begin
        rep_out <= 1'b0;
        if (run_in && g0 < 0 && g > 40) begin
            g0 = g;
        end
        fp_out <= !(g0 >= 0 && (g - g0) % 4096 == 0);
    end

    // Launch on falling edges, sink samples at bit end
    always @(negedge mclk_out) begin
        if (g0 >= 0 && g > g0) begin
            i  = g - 1 - g0;
            sr = {sr[6:0], tx_in};
            if (i % 8 == 3) begin
                rep_oe_n_out  <= oe_n_in;
                rep_drive_out <= drive_in;
            end
            if (i % 8 == 7) begin
                rep_frame_out <= 2'(i / 4096);
                rep_chan_out  <= 9'(i % 4096 / 8);
                rep_byte_out  <= sr;
                rep_out       <= 1'b1;
            end
        end
        for (int s = 0; s < 64; s++) begin
            n = 16 >> ((rx_rate_in[3*s+:3] > 3'h4) ? 3'h4 : rx_rate_in[3*s+:3]);
            i = g - g0 - int'(rx_offset_in[4*s+1+:3]);
            if (g0 >= 0 && i >= 0 && i % n == 0) begin
                b         = src_byte(i / 4096, s, i % 4096 / n / 8);
                rx_out[s] <= b[7 - i % 4096 / n % 8];
            end
        end
        g = g + 1;
    end
endmodule : tss_stream_partner
`default_nettype wire

// >>> dv/tss_switch_core_tb.sv
`timescale 1ns/1ps
`default_nettype none
module tss_switch_core_tb
    import tss_pkg::*;
;
    typedef struct {int f; int c; logic [7:0] b; logic hiz; logic nb;} tss_exp_t;
    logic          clk_sys_in;
    logic          rst_n_in;
    logic          mclk;
    logic          fp;
    logic          run;
    logic [63:0]   rx;
    logic [191:0]  rx_rate;
    logic [255:0]  rx_off;
    logic [191:0]  tx_rate;
    logic          cm_wr;
    logic          cm_high;
    logic [14:0]   cm_addr;
    logic [15:0]   cm_wdata;
    logic [63:0]   tx_data;
    logic [63:0]   tx_oe_n;
    logic [63:0]   drive;
    logic          gci;
    logic          rep;
    logic [1:0]    rep_f;
    logic [8:0]    rep_c;
    logic [7:0]    rep_b;
    logic          rep_oe_n;
    logic          rep_drv;
    logic [15:0]   t_w [11];
    logic [15:0]   r3;
    logic [15:0]   r4;
    int            mismatches;
    int            n_tests;
    int            seed;
    tss_exp_t      q [$];
    tss_exp_t      m;
    int            t_c [11] = '{3, 5, 7, 10, 11, 12, 20, 21, 100, 150, 250};
    int            t_s [11] = '{1, 40, 300, 0, 0, 0, 17, 17, 514, 1124, 0};
    int            t_lag [11] = '{2, 1, 2, 0, 0, 0, 0, 0, 0, 0, 0};
    logic [2:0]    t_m [11] = '{MODE_CONST, MODE_VAR, MODE_CONST, MODE_PROC, MODE_HIZ,
                                MODE_PROC, MODE_VAR, MODE_VAR, MODE_VAR, MODE_VAR, MODE_BERT};

    tss_switch_core i_tss_switch_core (
        .clk_sys_in                 (clk_sys_in),
        .rst_n_in                   (rst_n_in),
        .master_clock_input_in      (mclk),
        .frame_pulse_input_in       (fp),
        .rx_data_in                 (rx),
        .rx_rate_in                 (rx_rate),
        .rx_offset_in               (rx_off),
        .tx_rate_in                 (tx_rate),
        .cm_wr_in                   (cm_wr),
        .cm_high_in                 (cm_high),
        .cm_addr_in                 (cm_addr),
        .cm_wdata_in                (cm_wdata),
        .tx_data_out                (tx_data),
        .tx_oe_n_out                (tx_oe_n),
        .output_drive_indicator_out (drive),
        .gci_mode_out               (gci)
    );

    tss_stream_partner i_tss_stream_partner (
        .run_in        (run),
        .rx_rate_in    (rx_rate),
        .rx_offset_in  (rx_off),
        .tx_in         (tx_data[0]),
        .oe_n_in       (tx_oe_n[0]),
        .drive_in      (drive[0]),
        .mclk_out      (mclk),
        .fp_out        (fp),
        .rx_out        (rx),
        .rep_out       (rep),
        .rep_frame_out (rep_f),
        .rep_chan_out  (rep_c),
        .rep_byte_out  (rep_b),
        .rep_oe_n_out  (rep_oe_n),
        .rep_drive_out (rep_drv)
    );

    // ==========================================================
    // Clock
    initial begin
        clk_sys_in = 1'b0;
        forever #5 clk_sys_in = ~clk_sys_in;
    end

    // ==========================================================
    // Tasks
    task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
        n_tests++;
        if (got !== exp) begin
            mismatches++;
            $display("CHECK FAILED %0t byte %h exp %h", $time, got, exp);
        end
    endtask : chk8

    task automatic chk1(input logic got, input logic exp);
        n_tests++;
        if (got !== exp) begin
            mismatches++;
            $display("CHECK FAILED %0t flag %b exp %b", $time, got, exp);
        end
    endtask : chk1

    task automatic cm_set(input logic [5:0] s, input logic [8:0] c, input logic [2:0] md,
                          input logic [15:0] w);
        @(posedge clk_sys_in);
        cm_wr    <= 1'b1;
        cm_high  <= 1'b1;
        cm_addr  <= {s, c};
        cm_wdata <= {13'h0000, md};
        @(posedge clk_sys_in);
        cm_high  <= 1'b0;
        cm_wdata <= w;
        @(posedge clk_sys_in);
        cm_wr    <= 1'b0;
    endtask : cm_set

    task automatic test_done;
        if (mismatches == 0 && n_tests > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : test_done

    // ==========================================================
    // Monitor: oldest note against each reported channel
    always @(posedge rep) begin
        #1;
        if (q.size() > 0 && q[0].f == int'(rep_f) && q[0].c == int'(rep_c)) begin
            m = q.pop_front();
            chk1(rep_oe_n, m.hiz);  // Channel float
            chk1(rep_drv, !m.hiz);  // Drive flag
            if (!m.nb && !m.hiz) chk8(rep_b, m.b);  // Data
        end
    end

    // ==========================================================
    // Driver
    initial begin
        tss_exp_t e;
        int       k;
        rst_n_in = 1'b0;
        run      = 1'b0;
        cm_wr    = 1'b0;
        cm_high  = 1'b0;
        cm_addr  = '0;
        cm_wdata = '0;
        rx_rate  = {64{3'h4}};
        rx_rate[5:3] = 3'h0;  // Slow source stream
        rx_off   = '0;
        rx_off[11:8] = 4'h6;  // Late stream
        tx_rate  = '0;
        tx_rate[2:0] = 3'h4;
        mismatches = 0;
        n_tests  = 0;
        seed     = 32'hdb48;
        repeat (8) @(posedge clk_sys_in);
        rst_n_in <= 1'b1;
        repeat (4) @(posedge clk_sys_in);
        for (int s = 0; s < 64; s++)
            for (int c = 0; c < ((s == 0) ? 512 : 32); c++)
                cm_set(6'(s), 9'(c), MODE_HIZ, 16'h0000);
        r3 = 16'($random(seed));
        r4 = 16'($random(seed));
        for (int j = 0; j < 11; j++) begin
            t_w[j] = (t_m[j] == MODE_PROC) ? 16'($random(seed)) : 16'(t_s[j]);
            cm_set(6'h00, 9'(t_c[j]), t_m[j], t_w[j]);  // Modes
        end
        for (int f = 0; f < 3; f++)
            for (int j = 0; j < 11; j++)
                if (f >= t_lag[j] && (f < 2 || t_c[j] < 8)) begin
                    e.f   = f;
                    e.c   = t_c[j];
                    e.nb  = (t_m[j] == MODE_BERT);
                    e.hiz = (t_m[j] == MODE_HIZ) && !(j == 4 && f > 0);
                    e.b   = (j == 4) ? r4[7:0] : (j == 5 && f > 0) ? r3[7:0] : t_w[j][7:0];
                    if (t_m[j] <= MODE_CONST) begin
                        e.b = i_tss_stream_partner.src_byte(f - t_lag[j],
                              int'(t_w[j][14:9]), int'(t_w[j][8:0]));  // Delay
                    end
                    q.push_back(e);
                end
        run <= 1'b1;
        k = 0;
        while (!(rep === 1'b1 && rep_f === 2'h0 && rep_c === 9'h12c) && k < 60000) begin
            @(posedge clk_sys_in);
            k++;
        end
        if (k >= 60000) begin
            mismatches++;
            $display("CHECK FAILED %0t timeout waiting for frame 0 channel 300", $time);
        end
        cm_set(6'h00, 9'h00b, MODE_PROC, r4);  // Leave float mid-run
        cm_set(6'h00, 9'h00c, MODE_PROC, r3);  // New processor byte
        while (q.size() > 0 && k < 90000) begin
            @(posedge clk_sys_in);
            k++;
        end
        if (q.size() > 0) begin
            mismatches++;
            $display("CHECK FAILED %0t timeout, %0d notes left", $time, q.size());
        end
        chk1(gci, 1'b0);  // Idle-high pulse picks first convention
        chk1(&tx_oe_n[63:1] && !(|drive[63:1]), 1'b1);  // Floating streams
        test_done();
    end
endmodule : tss_switch_core_tb
`default_nettype wire
